// File: verilog/qsx_pkg.sv
// Purpose: constants for the execute-in-place read sequencer
// Assumes: one 32-bit control register plus a few own registers
// Notes:   offsets are word-aligned byte addresses
package qsx_pkg;
    localparam int          QSX_AW          = 4;
    localparam logic [3:0]  QSX_OFF_CTRL    = 4'h0;
    localparam logic [3:0]  QSX_OFF_ADDR    = 4'h4;
    localparam logic [3:0]  QSX_OFF_DATA    = 4'h8;
    localparam logic [3:0]  QSX_OFF_STAT    = 4'hc;
    localparam logic [31:0] QSX_CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] QSX_CTRL_MASK   = 32'h00ff_ffff;
    // field positions of the control register
    localparam int          QSX_DUMMY_LSB   = 21;
    localparam int          QSX_ADDRN_LSB   = 18;
    localparam int          QSX_OPC_LSB     = 10;
    localparam int          QSX_DLANE_LSB   = 8;
    localparam int          QSX_YLANE_LSB   = 6;
    localparam int          QSX_MLANE_LSB   = 4;
    localparam int          QSX_ALANE_LSB   = 2;
    localparam int          QSX_CLANE_LSB   = 0;
    localparam logic [2:0]  QSX_ADDRN_MAX   = 3'h4;
    localparam logic [7:0]  QSX_MODE_BITS   = 8'hff;
    // lane width encodings
    localparam logic [1:0]  QSX_LANE_SINGLE = 2'h0;
    localparam logic [1:0]  QSX_LANE_DUAL   = 2'h1;
    localparam logic [1:0]  QSX_LANE_QUAD   = 2'h2;
    localparam int          QSX_DIV         = 4;
    typedef enum logic [2:0] {
        QSX_IDLE, QSX_CMD, QSX_ADR, QSX_MODE, QSX_DUM, QSX_DAT, QSX_END
    } qsx_phase_t;
endpackage : qsx_pkg

// File: verilog/qsx_shifter.sv
// Purpose: link-side byte shifter running on the link clock
// Assumes: start arrives as a toggle from the system domain
// Notes:   one byte per request, lane width chosen per byte
`timescale 1ns/1ps
`default_nettype none
module qsx_shifter
(
    input  wire logic       clk_link,
    input  wire logic       rstn,
    input  wire logic       req_tgl,
    input  wire logic [7:0] tx_byte,
    input  wire logic [1:0] lane_w,
    input  wire logic       rx_en,
    input  wire logic [3:0] io_in,
    output logic [3:0]      io_out_ff,
    output logic [3:0]      io_oe_ff,
    output logic [7:0]      rx_byte_ff,
    output logic            ack_tgl_ff
);
    import qsx_pkg::*;

    logic       req_s1_ff;
    logic       req_s2_ff;
    logic       req_s3_ff;
    logic [7:0] sh_ff;
    logic [3:0] cnt_ff;
    logic       busy_ff;
    logic [7:0] nxt_sh;
    logic [3:0] nxt_cnt;
    logic       nxt_busy;
    logic [3:0] nxt_out;
    logic [3:0] nxt_oe;
    logic [7:0] nxt_rx;
    logic       nxt_ack;

    // bits moved per link clock for a lane width
    function automatic logic [3:0] qsx_step(input logic [1:0] w);
        qsx_step = (w == QSX_LANE_QUAD) ? 4'h4 : ((w == QSX_LANE_DUAL) ? 4'h2 : 4'h1);
    endfunction : qsx_step

    ////////////////////////////////////////////////////////////////////////
    // next state of shifter
    always_comb
    begin
        nxt_sh   = sh_ff;
        nxt_cnt  = cnt_ff;
        nxt_busy = busy_ff;
        nxt_out  = io_out_ff;
        nxt_oe   = io_oe_ff;
        nxt_rx   = rx_byte_ff;
        nxt_ack  = ack_tgl_ff;
        if (!busy_ff && (req_s2_ff != req_s3_ff))
        begin
            nxt_sh   = tx_byte;
            nxt_cnt  = 4'h8;
            nxt_busy = 1'b1;
            nxt_oe   = rx_en ? 4'h0 : io_oe_ff; // release lanes before the first sample
        end
        else if (busy_ff)
        begin
            unique case (lane_w)
                QSX_LANE_QUAD:
                begin
                    nxt_out = sh_ff[7:4];
                    nxt_oe  = rx_en ? 4'h0 : 4'hf;
                    nxt_sh  = {sh_ff[3:0], io_in};
                end
                QSX_LANE_DUAL:
                begin
                    nxt_out = {2'h0, sh_ff[7:6]};
                    nxt_oe  = rx_en ? 4'h0 : 4'h3;
                    nxt_sh  = {sh_ff[5:0], io_in[1:0]};
                end
                default:
                begin
                    nxt_out = {3'h0, sh_ff[7]};
                    nxt_oe  = rx_en ? 4'h0 : 4'h1; // single: io0 out, io1 in
                    nxt_sh  = {sh_ff[6:0], io_in[1]};
                end
            endcase
            nxt_cnt = cnt_ff - qsx_step(lane_w);
            if (nxt_cnt == 4'h0)
            begin
                nxt_busy = 1'b0;
                nxt_rx   = nxt_sh;
                nxt_ack  = ~ack_tgl_ff;
            end
        end
    end

    // register shifter state on the link clock
    always_ff @(posedge clk_link or negedge rstn)
    begin
        if (!rstn)
        begin
            req_s1_ff  <= 1'b0;
            req_s2_ff  <= 1'b0;
            req_s3_ff  <= 1'b0;
            sh_ff      <= 8'h00;
            cnt_ff     <= 4'h0;
            busy_ff    <= 1'b0;
            io_out_ff  <= 4'h0;
            io_oe_ff   <= 4'h0;
            rx_byte_ff <= 8'h00;
            ack_tgl_ff <= 1'b0;
        end
        else
        begin
            req_s1_ff  <= req_tgl;
            req_s2_ff  <= req_s1_ff;
            req_s3_ff  <= (!busy_ff) ? req_s2_ff : req_s3_ff;
            sh_ff      <= nxt_sh;
            cnt_ff     <= nxt_cnt;
            busy_ff    <= nxt_busy;
            io_out_ff  <= nxt_out;
            io_oe_ff   <= nxt_oe;
            rx_byte_ff <= nxt_rx;
            ack_tgl_ff <= nxt_ack;
        end
    end
endmodule : qsx_shifter
`default_nettype wire

// File: verilog/qsx_xip_read.sv
// Purpose: execute-in-place read sequencer with its control register
// Assumes: plain register port on clk_sys, link logic on clk_link
// Notes:   a read is started by writing the address register
`timescale 1ns/1ps
`default_nettype none
module qsx_xip_read
(
    input  wire logic                     clk_sys,
    input  wire logic                     rstn,
    input  wire logic                     clk_link,
    input  wire logic [qsx_pkg::QSX_AW-1:0] reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata_ff,
    output logic                          flash_cs_n_ff,
    output logic [3:0]                    flash_io_out,
    output logic [3:0]                    flash_io_oe,
    input  wire logic [3:0]               flash_io_in,
    output logic                          busy_ff
);
    import qsx_pkg::*;

    logic [31:0] ctrl_ff;
    logic [31:0] addr_ff;
    logic [31:0] data_ff;
    logic [1:0]  dcnt_ff;
    logic [2:0]  bcnt_ff;
    qsx_phase_t  ph_ff;
    logic        req_ff;
    logic        ack_s1_ff;
    logic        ack_s2_ff;
    logic        ack_s3_ff;
    logic        wait_ff;
    logic        err_ff;
    logic        done_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] nxt_addr;
    logic [31:0] nxt_data;
    logic [1:0]  nxt_dcnt;
    logic [2:0]  nxt_bcnt;
    qsx_phase_t  nxt_ph;
    logic        nxt_req;
    logic        nxt_wait;
    logic        nxt_err;
    logic        nxt_done;
    logic        nxt_busy;
    logic [31:0] nxt_rdata;
    logic [7:0]  tx_byte;
    logic [1:0]  lane_w;
    logic [7:0]  rx_byte;
    logic        ack_tgl;
    logic        ack_ev;
    logic        cs_link_n_ff;

    // field extraction
    function automatic logic [2:0] qsx_f3(input logic [31:0] r, input int lsb);
        qsx_f3 = 3'(r >> lsb);
    endfunction : qsx_f3

    function automatic logic [1:0] qsx_f2(input logic [31:0] r, input int lsb);
        qsx_f2 = 2'(r >> lsb);
    endfunction : qsx_f2

    ////////////////////////////////////////////////////////////////////////
    // byte and lane width for the current phase
    always_comb
    begin
        tx_byte = 8'h00;
        lane_w  = QSX_LANE_SINGLE;
        unique case (ph_ff)
            QSX_CMD:
            begin
                tx_byte = ctrl_ff[QSX_OPC_LSB +: 8];
                lane_w  = qsx_f2(ctrl_ff, QSX_CLANE_LSB);
            end
            QSX_ADR:
            begin
                tx_byte = 8'(addr_ff >> {bcnt_ff - 3'h1, 3'h0}); // msb first
                lane_w  = qsx_f2(ctrl_ff, QSX_ALANE_LSB);
            end
            QSX_MODE:
            begin
                tx_byte = QSX_MODE_BITS;
                lane_w  = qsx_f2(ctrl_ff, QSX_MLANE_LSB);
            end
            QSX_DUM:
            begin
                lane_w  = qsx_f2(ctrl_ff, QSX_YLANE_LSB);
            end
            QSX_DAT:
            begin
                lane_w  = qsx_f2(ctrl_ff, QSX_DLANE_LSB);
            end
            default:
            begin
                tx_byte = 8'h00;
            end
        endcase
    end

    assign ack_ev = ack_s2_ff ^ ack_s3_ff;

    ////////////////////////////////////////////////////////////////////////
    // register file and phase sequencer
    always_comb
    begin
        nxt_ctrl  = ctrl_ff;
        nxt_addr  = addr_ff;
        nxt_data  = data_ff;
        nxt_dcnt  = dcnt_ff;
        nxt_bcnt  = bcnt_ff;
        nxt_ph    = ph_ff;
        nxt_req   = req_ff;
        nxt_wait  = wait_ff;
        nxt_err   = err_ff;
        nxt_done  = done_ff;
        nxt_rdata = 32'h0000_0000;
        if (reg_wr && (reg_addr == QSX_OFF_CTRL) && (ph_ff == QSX_IDLE))
        begin
            nxt_ctrl = reg_wdata & QSX_CTRL_MASK;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                QSX_OFF_CTRL: nxt_rdata = ctrl_ff & QSX_CTRL_MASK;
                QSX_OFF_ADDR: nxt_rdata = addr_ff;
                QSX_OFF_DATA: nxt_rdata = data_ff;
                QSX_OFF_STAT: nxt_rdata = {29'h0, err_ff, done_ff, busy_ff};
                default:      nxt_rdata = 32'h0000_0000;
            endcase
        end
        unique case (ph_ff)
            QSX_IDLE:
            begin
                if (reg_wr && (reg_addr == QSX_OFF_ADDR))
                begin
                    nxt_addr = reg_wdata;
                    nxt_done = 1'b0;
                    if ((qsx_f3(ctrl_ff, QSX_ADDRN_LSB) > QSX_ADDRN_MAX)
                        || (qsx_f2(ctrl_ff, QSX_DLANE_LSB) == 2'h3)
                        || (qsx_f2(ctrl_ff, QSX_YLANE_LSB) == 2'h3))
                    begin
                        nxt_err = 1'b1;
                    end
                    else
                    begin
                        nxt_err  = 1'b0;
                        nxt_ph   = QSX_CMD;
                        nxt_req  = ~req_ff;
                        nxt_wait = 1'b1;
                    end
                end
            end
            QSX_END:
            begin
                nxt_done = 1'b1;
                nxt_ph   = QSX_IDLE;
            end
            default:
            begin
                if (wait_ff && ack_ev)
                begin
                    nxt_wait = 1'b0;
                    if (ph_ff == QSX_DAT)
                    begin
                        nxt_data = {rx_byte, data_ff[31:8]};
                        nxt_dcnt = dcnt_ff + 2'h1;
                    end
                    if (ph_ff == QSX_ADR || ph_ff == QSX_DUM)
                    begin
                        nxt_bcnt = bcnt_ff - 3'h1;
                    end
                end
                else if (!wait_ff)
                begin
                    // pick the next byte in the fixed order
                    nxt_wait = 1'b1;
                    nxt_req  = ~req_ff;
                    if (ph_ff == QSX_CMD)
                    begin
                        nxt_bcnt = qsx_f3(ctrl_ff, QSX_ADDRN_LSB);
                        nxt_ph   = (nxt_bcnt == 3'h0) ? QSX_MODE : QSX_ADR;
                    end
                    else if (ph_ff == QSX_ADR && bcnt_ff != 3'h0)
                    begin
                        nxt_ph = QSX_ADR;
                    end
                    else if (ph_ff == QSX_ADR)
                    begin
                        nxt_ph = QSX_MODE;
                    end
                    else if (ph_ff == QSX_MODE)
                    begin
                        nxt_bcnt = qsx_f3(ctrl_ff, QSX_DUMMY_LSB);
                        nxt_ph   = (nxt_bcnt == 3'h0) ? QSX_DAT : QSX_DUM;
                    end
                    else if (ph_ff == QSX_DUM && bcnt_ff != 3'h0)
                    begin
                        nxt_ph = QSX_DUM;
                    end
                    else if (ph_ff == QSX_DUM)
                    begin
                        nxt_ph = QSX_DAT;
                    end
                    else if (dcnt_ff == 2'h0)
                    begin
                        nxt_ph   = QSX_END;                  // four data bytes taken
                        nxt_wait = 1'b0;
                        nxt_req  = req_ff;
                    end
                end
            end
        endcase
        nxt_busy = (nxt_ph != QSX_IDLE);
    end

    // register the sequencer
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_ff      <= QSX_CTRL_RST;
            addr_ff      <= 32'h0000_0000;
            data_ff      <= 32'h0000_0000;
            dcnt_ff      <= 2'h0;
            bcnt_ff      <= 3'h0;
            ph_ff        <= QSX_IDLE;
            req_ff       <= 1'b0;
            ack_s1_ff    <= 1'b0;
            ack_s2_ff    <= 1'b0;
            ack_s3_ff    <= 1'b0;
            wait_ff      <= 1'b0;
            err_ff       <= 1'b0;
            done_ff      <= 1'b0;
            busy_ff      <= 1'b0;
            reg_rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            ctrl_ff      <= nxt_ctrl;
            addr_ff      <= nxt_addr;
            data_ff      <= nxt_data;
            dcnt_ff      <= nxt_dcnt;
            bcnt_ff      <= nxt_bcnt;
            ph_ff        <= nxt_ph;
            req_ff       <= nxt_req;
            ack_s1_ff    <= ack_tgl;
            ack_s2_ff    <= ack_s1_ff;
            ack_s3_ff    <= ack_s2_ff;
            wait_ff      <= nxt_wait;
            err_ff       <= nxt_err;
            done_ff      <= nxt_done;
            busy_ff      <= nxt_busy;
            reg_rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chip select on the link clock, from a synchronised busy level
    logic cs_s1_ff;
    logic cs_s2_ff;

    always_ff @(posedge clk_link or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_s1_ff     <= 1'b0;
            cs_s2_ff     <= 1'b0;
            cs_link_n_ff <= 1'b1;
        end
        else
        begin
            cs_s1_ff     <= busy_ff;
            cs_s2_ff     <= cs_s1_ff;
            cs_link_n_ff <= ~cs_s2_ff;
        end
    end

    assign flash_cs_n_ff = cs_link_n_ff;

    // link-side byte engine
    qsx_shifter u_shift
    (
        .clk_link   (clk_link),
        .rstn       (rstn),
        .req_tgl    (req_ff),
        .tx_byte    (tx_byte),
        .lane_w     (lane_w),
        .rx_en      (ph_ff == QSX_DAT),
        .io_in      (flash_io_in),
        .io_out_ff  (flash_io_out),
        .io_oe_ff   (flash_io_oe),
        .rx_byte_ff (rx_byte),
        .ack_tgl_ff (ack_tgl)
    );
endmodule : qsx_xip_read
`default_nettype wire

// File: testbench/qsx_xip_read_assertions.sv
// Purpose: port-level checks of the read sequencer
// Assumes: control shadow rebuilt from bus writes made while idle
// Notes:   status word holds {err,done,busy} in bits 2:0
`timescale 1ns/1ps
`default_nettype none
module qsx_xip_read_chk
    import qsx_pkg::*;
(
    input wire logic                         clk_sys,
    input wire logic                         rstn,
    input wire logic                         clk_link,
    input wire logic [qsx_pkg::QSX_AW-1:0]   reg_addr,
    input wire logic [31:0]                  reg_wdata,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [31:0]                  reg_rdata_ff,
    input wire logic                         flash_cs_n_ff,
    input wire logic [3:0]                   flash_io_out,
    input wire logic [3:0]                   flash_io_oe,
    input wire logic [3:0]                   flash_io_in,
    input wire logic                         busy_ff
);
    logic [31:0] ctrl_sh_ff;
    logic [31:0] nxt_ctrl_sh;
    logic [11:0] busy_cnt_ff;
    logic [11:0] nxt_busy_cnt;
    logic        start;
    logic        legal;
    logic        ctrl_rd;
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the control word and busy length
    assign start   = reg_wr && (reg_addr == QSX_OFF_ADDR) && !busy_ff;
    assign ctrl_rd = reg_rd && (reg_addr == QSX_OFF_CTRL);
    assign legal   = (ctrl_sh_ff[20:18] <= QSX_ADDRN_MAX) && (ctrl_sh_ff[9:8] != 2'h3)
                     && (ctrl_sh_ff[7:6] != 2'h3);
    always_comb
    begin
        nxt_ctrl_sh  = ctrl_sh_ff;
        if (reg_wr && (reg_addr == QSX_OFF_CTRL) && !busy_ff)
            nxt_ctrl_sh = reg_wdata & QSX_CTRL_MASK;
        nxt_busy_cnt = busy_ff ? busy_cnt_ff + 12'h001 : 12'h000;
    end
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_sh_ff  <= QSX_CTRL_RST;
            busy_cnt_ff <= 12'h000;
        end
        else
        begin
            ctrl_sh_ff  <= nxt_ctrl_sh;
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // register port
    a_ctrl_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(ctrl_rd) |-> reg_rdata_ff[31:24] == 8'h00) else $error("ctrl top byte not zero");
    a_ctrl_read_back: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(ctrl_rd) |-> reg_rdata_ff == $past(ctrl_sh_ff)) else $error("ctrl readback");
    a_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        !$past(reg_rd) |-> reg_rdata_ff == 32'h0) else $error("read data not cleared");
    // transaction start and refusal, select timing, busy bound and lane release
    a_start_sets_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
        start && legal |=> busy_ff) else $error("legal start did not run");
    a_reserved_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
        start && !legal |=> !busy_ff [*2]) else $error("reserved code started a read");
    a_cs_follows_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(busy_ff) |-> ##[1:60] !flash_cs_n_ff) else $error("select late");
    a_cs_inside_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(flash_cs_n_ff) |-> busy_ff) else $error("select without busy");
    a_busy_bounded: assert property (@(posedge clk_sys) disable iff (!rstn)
        busy_cnt_ff < 12'hbb8) else $error("read never finished");
    a_oe_deselect: assert property (@(posedge clk_link) disable iff (!rstn)
        flash_cs_n_ff && $past(flash_cs_n_ff) |-> flash_io_oe == 4'h0) else $error("lane driven");
    c_legal_start: cover property (@(posedge clk_sys) disable iff (!rstn) start && legal);
    c_refused_start: cover property (@(posedge clk_sys) disable iff (!rstn) start && !legal);
    c_ctrl_read: cover property (@(posedge clk_sys) disable iff (!rstn) ctrl_rd);
endmodule : qsx_xip_read_chk
bind qsx_xip_read qsx_xip_read_chk qsx_xip_read_chk_inst (
    .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .flash_cs_n_ff(flash_cs_n_ff), .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe),
    .flash_io_in(flash_io_in), .busy_ff(busy_ff));
`default_nettype wire

// File: testbench/qsx_flash_model.sv
// Purpose: behavioural serial flash answering read data
// Assumes: answer lane width is told by the bench
// Notes:   every data byte repeats one lane pattern
`timescale 1ns/1ps
`default_nettype none
module qsx_flash_model
    import qsx_pkg::*;
(
    input  wire logic       clk_link,
    input  wire logic       rstn,
    input  wire logic       flash_cs_n_ff,
    input  wire logic [3:0] flash_io_out,
    input  wire logic [3:0] flash_io_oe,
    input  wire logic [1:0] data_lane,
    output logic [3:0]      flash_io_in,
    output logic [7:0]      cmd_seen_ff
);
    logic [3:0] drv_ff;
    logic [3:0] resp;
    logic [3:0] cmd_cnt_ff;
    // first eight io0 bits driven in a select form the command byte
    always_ff @(posedge clk_link or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_cnt_ff  <= 4'h0;
            cmd_seen_ff <= 8'h00;
        end
        else if (flash_cs_n_ff)
            cmd_cnt_ff  <= 4'h0;
        else if (flash_io_oe[0] && (cmd_cnt_ff < 4'h8))
        begin
            cmd_cnt_ff  <= cmd_cnt_ff + 4'h1;
            cmd_seen_ff <= {cmd_seen_ff[6:0], flash_io_out[0]};
        end
    end
    // lane pattern per answer width: bytes 0xff, 0xaa, 0x66
    always_comb
    begin
        case (data_lane)
            QSX_LANE_QUAD: resp = 4'h6;
            QSX_LANE_DUAL: resp = 4'ha;
            default:       resp = 4'h2;
        endcase
    end
    // deselected lanes flip every cycle so no stale value survives
    always_ff @(posedge clk_link or negedge rstn)
    begin
        if (!rstn)
            drv_ff <= 4'h5;
        else
            drv_ff <= flash_cs_n_ff ? ~drv_ff : resp;
    end
    // the sequencer wins on each lane it enables
    assign flash_io_in = (flash_io_oe & flash_io_out) | (~flash_io_oe & drv_ff);
endmodule : qsx_flash_model
`default_nettype wire

// File: testbench/qsx_xip_read_test.sv
// Purpose: register-driven tests of the read sequencer
// Assumes: status {err,done,busy}, four data bytes a read
// Notes:   link clock free running, phase offset from system clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, act) \
    begin \
        total_checks++; \
        if ((act) !== (exp)) \
        begin \
            err_count++; \
            $display("wrong value %s expected %h seen %h", nm, exp, act); \
        end \
    end
module qsx_xip_read_test;
    import qsx_pkg::*;
    logic        clk_sys, clk_link, rstn, reg_wr, reg_rd, flash_cs_n_ff, busy_ff;
    logic [3:0]  reg_addr, flash_io_out, flash_io_oe, flash_io_in;
    logic [31:0] reg_wdata, reg_rdata_ff, d, ca, cb;
    logic [1:0]  lane_sel;
    logic [7:0]  cmd_seen;
    int          err_count, total_checks, low_cnt, la;
    ////////////////////////////////////////////////////////////////////////////////
    qsx_xip_read qsx_xip_read_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .flash_cs_n_ff(flash_cs_n_ff),
        .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe),
        .flash_io_in(flash_io_in), .busy_ff(busy_ff));
    qsx_flash_model qsx_flash_model_inst (.clk_link(clk_link), .rstn(rstn),
        .flash_cs_n_ff(flash_cs_n_ff), .flash_io_out(flash_io_out),
        .flash_io_oe(flash_io_oe), .data_lane(lane_sel), .flash_io_in(flash_io_in),
        .cmd_seen_ff(cmd_seen));
    // clocks and select-time counter
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        clk_link = 1'b0;
        #3;
        forever #40 clk_link = ~clk_link;
    end
    always @(posedge clk_link)
        if (flash_cs_n_ff === 1'b0)
            low_cnt++;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] mk(input logic [2:0] y, input logic [2:0] a,
        input logic [7:0] op, input logic [1:0] dl, input logic [1:0] yl, input logic [1:0] ol);
        return {8'h00, y, a, op, dl, yl, ol, ol, ol};
    endfunction : mk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata_ff;
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        while (busy_ff !== 1'b0 && n < 4000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 4000)
        begin
            err_count++;
            report_and_stop();
        end
    endtask : wait_idle
    // one read: returns select time in link cycles
    task automatic xfer(input logic [31:0] c, input logic [31:0] exp, output int lc);
        lane_sel = c[9:8];
        wr(QSX_OFF_CTRL, c);
        low_cnt = 0;
        wr(QSX_OFF_ADDR, 32'h0012_3456);
        wait_idle();
        lc = low_cnt;
        rd(QSX_OFF_STAT, d);
        `CHK("status", 3'h2, d[2:0])
        rd(QSX_OFF_DATA, d);
        `CHK("read data", exp, d)
        if (c[1:0] != QSX_LANE_DUAL && c[1:0] != QSX_LANE_QUAD)
            `CHK("command byte", c[QSX_OPC_LSB +: 8], cmd_seen)
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        lane_sel = 2'h0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(QSX_OFF_CTRL, d);
        `CHK("ctrl reset", 32'h0, d)
        rd(4'h2, d);
        `CHK("unmapped", 32'h0, d)
        wr(QSX_OFF_CTRL, 32'hffff_ffff);
        rd(QSX_OFF_CTRL, d);
        `CHK("ctrl all ones", 32'h00ff_ffff, d)
        $display("test registers done");
        xfer(mk(3'h0, 3'h0, 8'h03, 2'h0, 2'h0, 2'h0), 32'hffff_ffff, la);
        xfer(mk(3'h7, 3'h4, 8'h03, 2'h0, 2'h0, 2'h0), 32'hffff_ffff, low_cnt);
        `CHK("eleven more bytes", 1'b1, (low_cnt - la >= 110 && low_cnt - la <= 154))
        xfer(mk(3'h3, 3'h3, 8'heb, 2'h1, 2'h1, 2'h1), 32'haaaa_aaaa, la);
        xfer(mk(3'h1, 3'h2, 8'h6b, 2'h2, 2'h2, 2'h2), 32'h6666_6666, la);
        xfer(mk(3'h2, 3'h1, 8'hbb, 2'h2, 2'h0, 2'h3), 32'h6666_6666, la);
        $display("test lane reads done");
        for (int i = 0; i < 3; i++)
        begin
            ca = (i == 0) ? mk(3'h0, 3'h5, 8'h03, 2'h0, 2'h0, 2'h0)
               : (i == 1) ? mk(3'h0, 3'h4, 8'h03, 2'h3, 2'h0, 2'h0)
               : mk(3'h0, 3'h4, 8'h03, 2'h0, 2'h3, 2'h0);
            wr(QSX_OFF_CTRL, ca);
            wr(QSX_OFF_ADDR, 32'h0000_0010);
            rd(QSX_OFF_STAT, d);
            `CHK("refused err", 1'b1, d[2])
            `CHK("refused busy", 1'b0, d[0])
        end
        $display("test reserved codes done");
        cb = mk(3'h7, 3'h4, 8'h0b, 2'h0, 2'h0, 2'h0);
        wr(QSX_OFF_CTRL, cb);
        wr(QSX_OFF_ADDR, 32'h0000_0020);
        wr(QSX_OFF_CTRL, 32'h0000_0000);
        wait_idle();
        rd(QSX_OFF_CTRL, d);
        `CHK("ctrl held while busy", cb, d)
        $display("test busy write done");
        report_and_stop();
    end
endmodule : qsx_xip_read_test
`default_nettype wire
